//--- hw/output_gearbox_serializer.sv
// Output gearbox: parallel core words to double-rate serial lanes
//
// Overview of operation
// RULE1: Modes 7:1, 8:1 or dual 4:1.
// RULE2: Lanes 6..0, 7..0, or 3..0 and 7..4.
// RULE3: Stage one captures core word.
// RULE4: Stage two transfers word into fast registers.
// RULE5: Stage three shifts word onto serial output.
// RULE6: Lowest lane first, two bits per clock.
`timescale 1ns/1ps
`default_nettype none

module output_gearbox_serializer (
   // Clock and reset
   input  wire  logic                                CLK,
   input  wire  logic                                RST_N,
   // Mode select from core
   input  wire  gearbox_pkg::gear_mode_t             MODE,
   // Parallel word from core
   input  wire  logic [gearbox_pkg::WORD_W-1:0]      D,
   // Word accepted pulse toward core
   output logic                                      WORD_TAKE,
   // Serial lanes toward output buffers
   output gearbox_pkg::ser_pair_t                    SER_A,
   output gearbox_pkg::ser_pair_t                    SER_B
);

   // ==========================================================
   // Mode decoding
   function automatic logic [gearbox_pkg::CNT_W-1:0] word_len(
      input gearbox_pkg::gear_mode_t m);
      case (m)
         gearbox_pkg::MODE_SER7:   word_len = 5'(gearbox_pkg::LEN_SER7);
         gearbox_pkg::MODE_DDR4X2: word_len = 5'(gearbox_pkg::LEN_DDR4);
         default:                  word_len = 5'(gearbox_pkg::LEN_DDR8);
      endcase
   endfunction

   function automatic logic [gearbox_pkg::WORD_W-1:0] lane_word(
      input gearbox_pkg::gear_mode_t m,
      input logic [gearbox_pkg::WORD_W-1:0] w,
      input int lane);
      logic [gearbox_pkg::WORD_W-1:0] r;
      r = gearbox_pkg::WORD_RST;
      case (m)
         gearbox_pkg::MODE_SER7: begin
            if (lane == 0) r = {1'b0, w[6:0]};
         end
         gearbox_pkg::MODE_DDR4X2: begin
            if (lane == 0) r = {4'h0, w[3:0]};
            else           r = {4'h0, w[7:4]};
         end
         default: begin
            if (lane == 0) r = w;
         end
      endcase
      lane_word = r;
   endfunction

   // ==========================================================
   // Mode register and restart on change
   gearbox_pkg::gear_mode_t              mode_reg;
   logic                                 restart_reg;
   logic [gearbox_pkg::WORD_W-1:0]       cap_reg;
   logic [gearbox_pkg::WORD_W-1:0]       xfer_reg;
   logic [gearbox_pkg::LANE_CNT-1:0]     load_lane;
   logic                                 take_reg;
   gearbox_pkg::ser_pair_t               ser_a_reg;
   gearbox_pkg::ser_pair_t               ser_b_reg;

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         mode_reg    <= gearbox_pkg::MODE_DDR8;
         restart_reg <= 1'b1;
      end else begin
         mode_reg    <= MODE; // [RULE1]
         restart_reg <= (MODE != mode_reg);
      end
   end

   // ==========================================================
   // Stage one: core word capture
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         cap_reg <= gearbox_pkg::WORD_RST;
      end else if (load_lane[0]) begin
         cap_reg <= D; // [RULE3]
      end
   end

   // ==========================================================
   // Stage two: transfer into shifter-side register
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         xfer_reg <= gearbox_pkg::WORD_RST;
      end else if (load_lane[0]) begin
         xfer_reg <= cap_reg; // [RULE4]
      end
   end

   // ==========================================================
   // Word accepted pulse
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         take_reg <= 1'b0;
      end else begin
         take_reg <= load_lane[0];
      end
   end

   // ==========================================================
   // Stage three: per-lane residue shifters
   gearbox_pkg::ser_pair_t lane_out [gearbox_pkg::LANE_CNT];

   genvar g;
   generate
      for (g = 0; g < gearbox_pkg::LANE_CNT; g++) begin : g_lane
         logic [gearbox_pkg::SH_W-1:0]  sh_reg;
         logic [gearbox_pkg::SH_W-1:0]  sh_next;
         logic [gearbox_pkg::CNT_W-1:0] cnt_reg;
         logic [gearbox_pkg::CNT_W-1:0] cnt_next;
         logic [gearbox_pkg::CNT_W-1:0] rem_cnt;
         logic [gearbox_pkg::SH_W-1:0]  word_ext;
         logic                          ld;

         always_comb begin
            word_ext = {8'h00, lane_word(mode_reg, xfer_reg, g)}; // [RULE2]
            rem_cnt  = (cnt_reg >= 5'(gearbox_pkg::BITS_PER_CK)) ?
                       5'(cnt_reg - 5'(gearbox_pkg::BITS_PER_CK)) :
                       gearbox_pkg::CNT_RST;
            ld       = (rem_cnt < 5'(gearbox_pkg::BITS_PER_CK));
            sh_next  = sh_reg >> gearbox_pkg::BITS_PER_CK; // [RULE5]
            cnt_next = rem_cnt;
            if (ld) begin
               sh_next  = sh_next | (word_ext << rem_cnt);
               cnt_next = 5'(rem_cnt + word_len(mode_reg));
            end
         end

         always_ff @(posedge CLK or negedge RST_N) begin
            if (!RST_N) begin
               sh_reg  <= gearbox_pkg::SH_RST;
               cnt_reg <= gearbox_pkg::CNT_RST;
            end else if (restart_reg) begin
               sh_reg  <= gearbox_pkg::SH_RST;
               cnt_reg <= gearbox_pkg::CNT_RST;
            end else begin
               sh_reg  <= sh_next;
               cnt_reg <= cnt_next;
            end
         end

         assign load_lane[g] = ld && !restart_reg;
         assign lane_out[g]  = gearbox_pkg::ser_pair_t'(sh_reg[1:0]); // [RULE6]
      end
   endgenerate

   // ==========================================================
   // Registered serial outputs
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ser_a_reg <= '0;
         ser_b_reg <= '0;
      end else begin
         ser_a_reg <= lane_out[0]; // [RULE5]
         ser_b_reg <= (mode_reg == gearbox_pkg::MODE_DDR4X2) ?
                      lane_out[1] : '0; // [RULE1]
      end
   end

   assign WORD_TAKE = take_reg;
   assign SER_A     = ser_a_reg;
   assign SER_B     = ser_b_reg;

   // ==========================================================
   // Assertions
   sequence s_take_gap3;
      !load_lane[0] [*3] ##1 load_lane[0];
   endsequence

   sequence s_take_gap2;
      !load_lane[0] [*2] ##1 load_lane[0];
   endsequence

   sequence s_take_gap1;
      !load_lane[0] ##1 load_lane[0];
   endsequence

   a_take_one_cycle: assert property (@(posedge CLK) // [RULE3]
      disable iff (!RST_N)
      WORD_TAKE |=> !WORD_TAKE)
      else $error("word taken pulse longer than one cycle");

   a_rate_eight: assert property (@(posedge CLK) // [RULE6]
      disable iff (!RST_N || restart_reg)
      (load_lane[0] && mode_reg == gearbox_pkg::MODE_DDR8) |=>
      s_take_gap3)
      else $error("eight-to-one word rate wrong");

   a_rate_four: assert property (@(posedge CLK) // [RULE6]
      disable iff (!RST_N || restart_reg)
      (load_lane[0] && mode_reg == gearbox_pkg::MODE_DDR4X2) |=>
      s_take_gap1)
      else $error("four-to-one word rate wrong");

   a_rate_seven: assert property (@(posedge CLK) // [RULE1]
      disable iff (!RST_N || restart_reg)
      (load_lane[0] && mode_reg == gearbox_pkg::MODE_SER7) |=>
      (s_take_gap2 or s_take_gap3))
      else $error("seven-to-one word rate wrong");

   a_capture_stage: assert property (@(posedge CLK) // [RULE3]
      disable iff (!RST_N)
      load_lane[0] |=>
      (cap_reg == $past(D)) && (xfer_reg == $past(cap_reg)))
      else $error("capture or transfer stage wrong");

   a_take_pulse: assert property (@(posedge CLK) // [RULE4]
      disable iff (!RST_N)
      load_lane[0] |=> WORD_TAKE)
      else $error("word taken pulse missing");

   a_first_bit_out: assert property (@(posedge CLK) // [RULE6]
      disable iff (!RST_N)
      (load_lane[0] && mode_reg == gearbox_pkg::MODE_DDR8) |=> ##1
      ((SER_A.rise == $past(xfer_reg[0], 2)) &&
       (SER_A.fall == $past(xfer_reg[1], 2))))
      else $error("lowest lane not sent first");

   a_lane_b_idle: assert property (@(posedge CLK) // [RULE2]
      disable iff (!RST_N)
      (mode_reg != gearbox_pkg::MODE_DDR4X2) |=> (SER_B == '0))
      else $error("second lane active outside dual mode");

endmodule // output_gearbox_serializer

`default_nettype wire

//--- inc/gearbox_pkg.sv
// Constants and types shared by the output gearbox serializer
package gearbox_pkg;
   // ==========================================================
   // Gearbox modes
   typedef enum logic [1:0] {
      MODE_SER7    = 2'b00,
      MODE_DDR8    = 2'b01,
      MODE_DDR4X2  = 2'b10,
      MODE_SPARE   = 2'b11
   } gear_mode_t;

   // ==========================================================
   // Word and shifter geometry
   localparam int WORD_W      = 8;
   localparam int LANE_CNT    = 2;
   localparam int HALF_W      = 4;
   localparam int SH_W        = 16;
   localparam int CNT_W       = 5;
   localparam int LEN_SER7    = 7;
   localparam int LEN_DDR8    = 8;
   localparam int LEN_DDR4    = 4;
   localparam int BITS_PER_CK = 2;

   // ==========================================================
   // Reset values
   localparam logic [WORD_W-1:0] WORD_RST = 8'h00;
   localparam logic [SH_W-1:0]   SH_RST   = 16'h0000;
   localparam logic [CNT_W-1:0]  CNT_RST  = 5'h00;

   // ==========================================================
   // Double-rate output pair: rise half goes out first
   typedef struct packed {
      logic fall;
      logic rise;
   } ser_pair_t;
endpackage

//--- test/core_word_src.sv
// Core-side word source: holds each word until accepted
`timescale 1ns/1ps
`default_nettype none
module core_word_src (
   // Clock and reset
   input  wire logic       CLK,
   input  wire logic       RST_N,
   // Handshake and word
   input  wire logic       WORD_TAKE,
   output logic [7:0]      D
);
   logic [7:0] idx_reg;
   // ==========================================================
   // Word held until taken, then next
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) idx_reg <= #1 8'h00;
      else if (WORD_TAKE) idx_reg <= #1 idx_reg + 8'h01;
   end
   assign D = 8'h35 + 8'h4B * idx_reg;
endmodule // core_word_src
`default_nettype wire

//--- test/tb_top.sv
// Testbench for the output gearbox serializer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic                   CLK;
   logic                   RST_N;
   gearbox_pkg::gear_mode_t MODE;
   logic [7:0]             D;
   logic                   WORD_TAKE;
   gearbox_pkg::ser_pair_t SER_A;
   gearbox_pkg::ser_pair_t SER_B;
   logic [63:0]            sa;
   logic [63:0]            sb;
   int                     miscompares = 0;
   int                     check_count = 0;
   int                     cycles = 0;
   output_gearbox_serializer DUT (.CLK(CLK), .RST_N(RST_N), .MODE(MODE),
      .D(D), .WORD_TAKE(WORD_TAKE), .SER_A(SER_A), .SER_B(SER_B));
   core_word_src SRC (.CLK(CLK), .RST_N(RST_N), .WORD_TAKE(WORD_TAKE),
      .D(D));
   // ==========================================================
   // Clock and timeout
   initial begin
      CLK = 1'b0;
      forever #2.5 CLK = ~CLK;
   end
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic check_word(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // ==========================================================
   // Reset, mode, skip pipeline fill, collect 16 cycles of pairs
   task automatic run_mode(input gearbox_pkg::gear_mode_t m);
      int n;
      RST_N = 1'b0;
      MODE = m;
      repeat (6) @(posedge CLK);
      check_word({3'h0, WORD_TAKE, SER_B, SER_A}, 8'h00);
      #1 RST_N = 1'b1;
      n = 0;
      while (n < 3) begin
         @(posedge CLK);
         #1;
         if (WORD_TAKE === 1'b1) n++;
      end
      for (int k = 0; k < 16; k++) begin
         @(posedge CLK);
         #1;
         {sa[2*k+1], sa[2*k]} = SER_A;
         {sb[2*k+1], sb[2*k]} = SER_B;
      end
   endtask
   // Compare words of one lane, len bits each, lowest first
   task automatic check_lane(input logic [63:0] s, input int len,
                             input int sh, input int cnt);
      logic [7:0] msk;
      msk = 8'hFF >> (8 - len);
      for (int i = 0; i < cnt; i++)
         check_word(8'(s >> (i * len)) & msk,
                    8'((8'h35 + 8'h4B * i) >> sh) & msk);
   endtask
   // ==========================================================
   // Scenarios
   task automatic test_ser7();
      run_mode(gearbox_pkg::MODE_SER7);
      check_lane(sa, 7, 0, 4);
      check_word(sb[7:0], 8'h00);
   endtask
   task automatic test_ddr8();
      run_mode(gearbox_pkg::MODE_DDR8);
      check_lane(sa, 8, 0, 4);
      check_word(sb[7:0], 8'h00);
   endtask
   task automatic test_dual4();
      run_mode(gearbox_pkg::MODE_DDR4X2);
      check_lane(sa, 4, 0, 8);
      check_lane(sb, 4, 4, 8);
   endtask
   task automatic test_spare();
      run_mode(gearbox_pkg::MODE_SPARE);
      check_lane(sa, 8, 0, 4);
   endtask
   initial begin
      RST_N = 1'b0;
      MODE = gearbox_pkg::MODE_SER7;
      #1;
      test_ser7();
      test_ddr8();
      test_dual4();
      test_spare();
      test_ser7();
      stop_test();
   end
endmodule // tb_top
`default_nettype wire
